// *** logic/single_pin_uart_consts.vh ***
// constants for the single pin uart user interface
`ifndef SINGLE_PIN_UART_CONSTS_VH
`define SINGLE_PIN_UART_CONSTS_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFS_MODE 8'h00
`define OFS_STATUS 8'h04
`define OFS_STATUS_CLEAR 8'h08
`define OFS_IRQ_SET 8'h0c
`define OFS_IRQ_CLEAR 8'h10
`define OFS_IRQ_MASK 8'h14
`define OFS_RX_BYTE 8'h18
`define OFS_TX_BYTE 8'h1c
`define OFS_DIVISOR 8'h20

// ----------------------------------------
// status bit positions
// ----------------------------------------
`define BIT_COLLIDE 13
`define BIT_OVERRUN 10
`define BIT_RX_READY 9
`define BIT_IDLE 8
`define BIT_CLOCK_ON 2
`define BIT_BUSY 0

// ----------------------------------------
// modes, reset values, timing
// ----------------------------------------
`define MODE_OFF 2'h0
`define MODE_RX 2'h1
`define MODE_TX 2'h2
`define MODE_RESYNC 2'h3
`define RST_WORD 32'h00000000
`define RST_DIVISOR 16'h0000
`define SYNC_PATTERN 8'h55
`define MIN_DIVISOR 32
`define RATE_STEP 8
`define SYNC_CYCLES 4
`define SYNC_EDGES 3'h4

`endif

// *** logic/serial_bit_engine.v ***
// serial transmitter, receiver and rate measurement on one pin
`timescale 1ns/1ps
`default_nettype none
`include "single_pin_uart_consts.vh"
module serial_bit_engine #(
   parameter DIV_W = 16
) (
   input wire clk,
   input wire nrst,
   input wire [DIV_W-1:0] divisor,
   input wire rx_en,
   input wire tx_en,
   input wire meas_en,
   input wire tx_start,
   input wire [7:0] tx_data,
   input wire line_in,
   output reg line_out,
   output reg line_oe,
   output wire tx_active,
   output wire collide,
   output reg rx_done,
   output reg [7:0] rx_data,
   output reg meas_done,
   output reg [DIV_W-1:0] meas_value
);
   // ----------------------------------------
   // rate accumulator
   // ----------------------------------------
   localparam [DIV_W:0] STEP = `RATE_STEP;
   function acc_tick;
      input [DIV_W:0] acc;
      input [DIV_W-1:0] div;
      begin
         acc_tick = (acc + STEP) >= {1'b0, div};
      end
   endfunction
   function [DIV_W:0] acc_next;
      input [DIV_W:0] acc;
      input [DIV_W-1:0] div;
      begin
         if (acc_tick(acc, div)) begin
            acc_next = acc + STEP - {1'b0, div};
         end else begin
            acc_next = acc + STEP;
         end
      end
   endfunction

   reg [DIV_W:0] rx_acc_q;
   reg [DIV_W:0] tx_acc_q;
   reg rx_run_q;
   reg tx_run_q;
   reg [3:0] rx_cnt_q;
   reg [3:0] tx_cnt_q;
   reg [7:0] rx_sh_q;
   reg [9:0] tx_sh_q;
   reg prev_q;
   reg meas_run_q;
   reg [2:0] edges_q;
   reg [DIV_W-1:0] meas_cnt_q;
   wire fall = prev_q & ~line_in;

   assign tx_active = tx_run_q;
   assign collide = tx_run_q & rx_en & (line_in != line_out);

   // ----------------------------------------
   // transmitter
   // ----------------------------------------
   always @(posedge clk) begin
      if (!nrst) begin
         tx_run_q <= 1'b0;
         tx_acc_q <= {(DIV_W+1){1'b0}};
         tx_cnt_q <= 4'h0;
         tx_sh_q <= 10'h3ff;
         line_out <= 1'b1;
         line_oe <= 1'b0;
      end else if (!tx_run_q) begin
         line_oe <= 1'b0;
         line_out <= 1'b1;
         if (tx_start && tx_en) begin
            tx_run_q <= 1'b1;
            tx_acc_q <= {(DIV_W+1){1'b0}};
            tx_cnt_q <= 4'h0;
            tx_sh_q <= {1'b1, tx_data, 1'b0};
            line_out <= 1'b0;
            line_oe <= 1'b1;
         end
      end else begin
         tx_acc_q <= acc_next(tx_acc_q, divisor);
         if (acc_tick(tx_acc_q, divisor)) begin
            tx_cnt_q <= tx_cnt_q + 4'h1;
            tx_sh_q <= {1'b1, tx_sh_q[9:1]};
            line_out <= tx_sh_q[1];
            if (tx_cnt_q == 4'h9) begin
               tx_run_q <= 1'b0;
               line_oe <= 1'b0;
               line_out <= 1'b1;
            end
         end
      end
   end

   // ----------------------------------------
   // receiver
   // ----------------------------------------
   always @(posedge clk) begin
      if (!nrst) begin
         rx_run_q <= 1'b0;
         rx_acc_q <= {(DIV_W+1){1'b0}};
         rx_cnt_q <= 4'h0;
         rx_sh_q <= 8'h00;
         rx_done <= 1'b0;
         rx_data <= 8'h00;
      end else begin
         rx_done <= 1'b0;
         if (!rx_en) begin
            rx_run_q <= 1'b0;
         end else if (!rx_run_q) begin
            if (fall) begin
               rx_run_q <= 1'b1;
               rx_acc_q <= {2'b00, divisor[DIV_W-1:1]};
               rx_cnt_q <= 4'h0;
            end
         end else begin
            rx_acc_q <= acc_next(rx_acc_q, divisor);
            if (acc_tick(rx_acc_q, divisor)) begin
               rx_cnt_q <= rx_cnt_q + 4'h1;
               if (rx_cnt_q == 4'h0) begin
                  rx_run_q <= ~line_in;
               end else if (rx_cnt_q == 4'h9) begin
                  rx_run_q <= 1'b0;
                  rx_done <= line_in;
                  rx_data <= rx_sh_q;
               end else begin
                  rx_sh_q <= {line_in, rx_sh_q[7:1]};
               end
            end
         end
      end
   end

   // ----------------------------------------
   // sync byte measurement
   // ----------------------------------------
   always @(posedge clk) begin
      if (!nrst) begin
         prev_q <= 1'b1;
         meas_run_q <= 1'b0;
         edges_q <= 3'h0;
         meas_cnt_q <= {DIV_W{1'b0}};
         meas_done <= 1'b0;
         meas_value <= {DIV_W{1'b0}};
      end else begin
         prev_q <= line_in;
         meas_done <= 1'b0;
         if (!meas_en) begin
            meas_run_q <= 1'b0;
         end else if (!meas_run_q) begin
            if (fall) begin
               meas_run_q <= 1'b1;
               edges_q <= 3'h0;
               meas_cnt_q <= {DIV_W{1'b0}};
            end
         end else begin
            meas_cnt_q <= meas_cnt_q + {{(DIV_W-1){1'b0}}, 1'b1};
            if (fall) begin
               edges_q <= edges_q + 3'h1;
               if (edges_q == `SYNC_EDGES - 3'h1) begin
                  meas_run_q <= 1'b0;
                  meas_done <= 1'b1;
                  meas_value <= meas_cnt_q + {{(DIV_W-1){1'b0}}, 1'b1};
               end
            end
         end
      end
   end
endmodule
`default_nettype wire

// *** logic/single_pin_uart_user_if.v ***
// apb register front end of the single pin uart
//
// Local design decision: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "single_pin_uart_consts.vh"
module single_pin_uart_user_if #(
   parameter ADDR_W = 8,
   parameter DIV_W = 16,
   parameter SYNC_CYCLES = `SYNC_CYCLES
) (
   input wire clk,
   input wire nrst,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [ADDR_W-1:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire osc_clock_on,
   input wire line_in,
   output wire line_out,
   output wire line_oe,
   output wire irq
);
   // ----------------------------------------
   // declarations
   // ----------------------------------------
   localparam [3:0] SYNC_LOAD = SYNC_CYCLES;
   localparam [1:0] F_IDLE = 2'h0;
   localparam [1:0] F_RXRDY = 2'h1;
   localparam [1:0] F_OVR = 2'h2;
   localparam [1:0] F_COL = 2'h3;

   reg [1:0] mode_q;
   reg [DIV_W-1:0] divisor_q;
   reg [7:0] tx_byte_q;
   reg [7:0] rx_byte_q;
   reg unread_q;
   reg synced_q;
   reg [3:0] sync_cnt_q;
   reg busy_prev_q;
   reg [3:0] flags_q;
   reg [3:0] mask_q;
   reg err_q;

   wire [7:0] rx_data;
   wire rx_done;
   wire meas_done;
   wire [DIV_W-1:0] meas_value;
   wire tx_active;
   wire collide;
   wire busy;
   wire [3:0] flag_set;
   wire [3:0] flag_clr;
   wire [3:0] wr_bits;
   wire setup = psel & ~penable;
   wire access = psel & penable;
   wire wr = access & pwrite;
   wire [7:0] addr = paddr[7:0];

   // ----------------------------------------
   // address decoding
   // ----------------------------------------
   function mapped;
      input [7:0] a;
      begin
         if (a[1:0] != 2'b00) begin
            mapped = 1'b0;
         end else if (a > `OFS_DIVISOR) begin
            mapped = 1'b0;
         end else begin
            mapped = 1'b1;
         end
      end
   endfunction

   function [3:0] flag_bits;
      input [31:0] w;
      begin
         flag_bits = {w[`BIT_COLLIDE], w[`BIT_OVERRUN], w[`BIT_RX_READY], w[`BIT_IDLE]};
      end
   endfunction

   function [31:0] flag_word;
      input [3:0] f;
      begin
         flag_word = `RST_WORD;
         flag_word[`BIT_COLLIDE] = f[F_COL];
         flag_word[`BIT_OVERRUN] = f[F_OVR];
         flag_word[`BIT_RX_READY] = f[F_RXRDY];
         flag_word[`BIT_IDLE] = f[F_IDLE];
      end
   endfunction

   wire wr_mode = wr & (addr == `OFS_MODE) & ~busy;
   wire wr_div = wr & (addr == `OFS_DIVISOR) & ~busy;
   wire wr_tx = wr & (addr == `OFS_TX_BYTE) & ~busy;
   wire wr_sclr = wr & (addr == `OFS_STATUS_CLEAR);
   wire wr_iset = wr & (addr == `OFS_IRQ_SET);
   wire wr_iclr = wr & (addr == `OFS_IRQ_CLEAR);
   wire rd_rx = access & ~pwrite & (addr == `OFS_RX_BYTE);

   assign wr_bits = flag_bits(pwdata);
   assign pready = access;
   assign pslverr = access & err_q;

   // ----------------------------------------
   // mode, divisor and transmit byte
   // ----------------------------------------
   wire rx_mode = (mode_q == `MODE_RX) | ((mode_q == `MODE_RESYNC) & synced_q);
   wire tx_mode = (mode_q == `MODE_TX);
   wire meas_mode = (mode_q == `MODE_RESYNC) & ~synced_q;

   always @(posedge clk) begin
      if (!nrst) begin
         mode_q <= `MODE_OFF;
         divisor_q <= `RST_DIVISOR;
         tx_byte_q <= 8'h00;
         synced_q <= 1'b0;
      end else begin
         if (wr_mode) begin
            mode_q <= pwdata[1:0];
            synced_q <= 1'b0;
         end
         if (wr_div) begin
            divisor_q <= pwdata[DIV_W-1:0];
            synced_q <= 1'b1;
         end else if (meas_mode && meas_done) begin
            divisor_q <= meas_value;
            synced_q <= 1'b1;
         end
         if (wr_tx) begin
            tx_byte_q <= pwdata[7:0];
         end
      end
   end

   // ----------------------------------------
   // crossing busy and idle edge
   // ----------------------------------------
   assign busy = (sync_cnt_q != 4'h0) | tx_active;

   always @(posedge clk) begin
      if (!nrst) begin
         sync_cnt_q <= 4'h0;
         busy_prev_q <= 1'b0;
      end else begin
         busy_prev_q <= busy;
         if (wr_mode || wr_div || wr_tx) begin
            sync_cnt_q <= SYNC_LOAD;
         end else if (sync_cnt_q != 4'h0) begin
            sync_cnt_q <= sync_cnt_q - 4'h1;
         end
      end
   end

   // ----------------------------------------
   // receive byte and unread tracking
   // ----------------------------------------
   wire rx_take = rx_done & rx_mode;

   always @(posedge clk) begin
      if (!nrst) begin
         rx_byte_q <= 8'h00;
         unread_q <= 1'b0;
      end else begin
         if (rx_take) begin
            rx_byte_q <= rx_data;
            unread_q <= 1'b1;
         end else if (rd_rx) begin
            unread_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // sticky flags and mask
   // ----------------------------------------
   assign flag_set[F_IDLE] = busy_prev_q & ~busy;
   assign flag_set[F_RXRDY] = rx_take;
   assign flag_set[F_OVR] = rx_take & unread_q & ~rd_rx;
   assign flag_set[F_COL] = collide;
   assign flag_clr = wr_sclr ? wr_bits : 4'h0;

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_flag
         always @(posedge clk) begin
            if (!nrst) begin
               flags_q[gi] <= 1'b0;
               mask_q[gi] <= 1'b0;
            end else begin
               if (flag_set[gi]) begin
                  flags_q[gi] <= 1'b1;
               end else if (flag_clr[gi]) begin
                  flags_q[gi] <= 1'b0;
               end
               if (wr_iset && wr_bits[gi]) begin
                  mask_q[gi] <= 1'b1;
               end else if (wr_iclr && wr_bits[gi]) begin
                  mask_q[gi] <= 1'b0;
               end
            end
         end
      end
   endgenerate

   assign irq = |(flags_q & mask_q);

   // ----------------------------------------
   // read data
   // ----------------------------------------
   reg [31:0] rdata_d;
   always @* begin
      rdata_d = `RST_WORD;
      if (addr == `OFS_MODE) begin
         rdata_d[1:0] = mode_q;
      end else if (addr == `OFS_STATUS) begin
         rdata_d = flag_word(flags_q);
         rdata_d[`BIT_CLOCK_ON] = osc_clock_on;
         rdata_d[`BIT_BUSY] = busy;
      end else if (addr == `OFS_IRQ_MASK) begin
         rdata_d = flag_word(mask_q);
      end else if (addr == `OFS_RX_BYTE) begin
         rdata_d[7:0] = rx_byte_q;
      end else if (addr == `OFS_TX_BYTE) begin
         rdata_d[7:0] = tx_byte_q;
      end else if (addr == `OFS_DIVISOR) begin
         rdata_d[DIV_W-1:0] = divisor_q;
      end
   end

   always @(posedge clk) begin
      if (!nrst) begin
         prdata <= `RST_WORD;
         err_q <= 1'b0;
      end else if (setup) begin
         prdata <= pwrite ? `RST_WORD : rdata_d;
         err_q <= ~mapped(addr) | (paddr > `OFS_DIVISOR);
      end
   end

   // ----------------------------------------
   // serial engine
   // ----------------------------------------
   serial_bit_engine #(
      .DIV_W(DIV_W)
   ) u_engine (
      .clk(clk),
      .nrst(nrst),
      .divisor(divisor_q),
      .rx_en(rx_mode),
      .tx_en(tx_mode),
      .meas_en(meas_mode),
      .tx_start(wr_tx),
      .tx_data(pwdata[7:0]),
      .line_in(line_in),
      .line_out(line_out),
      .line_oe(line_oe),
      .tx_active(tx_active),
      .collide(collide),
      .rx_done(rx_done),
      .rx_data(rx_data),
      .meas_done(meas_done),
      .meas_value(meas_value)
   );
endmodule
`default_nettype wire

// *** testbench/single_pin_uart_chk.sv ***
// assertion checker for the single pin uart register front end
`timescale 1ns/1ps
`default_nettype none
module single_pin_uart_chk #(
   parameter int ADDR_W = 8
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic osc_clock_on,
   input wire logic line_in,
   input wire logic line_out,
   input wire logic line_oe,
   input wire logic irq
);
   wire rd_acc;
   wire wr_acc;
   assign rd_acc = psel && penable && !pwrite;
   assign wr_acc = psel && penable && pwrite;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);
   // ----------------------------------------
   // properties
   // ----------------------------------------
   a_mode_field: assert property (rd_acc && paddr == 8'h00 |-> prdata[31:2] == 30'h0)
      else $error("mode read shows upper bits");
   a_status_bits: assert property (rd_acc && paddr == 8'h04 |-> (prdata & 32'hffffd8fa) == 0)
      else $error("status read shows unused bits");
   a_clock_flag: assert property (rd_acc && paddr == 8'h04 |-> prdata[2] == $past(osc_clock_on))
      else $error("clock flag does not follow oscillator");
   a_mask_fields: assert property (rd_acc && paddr == 8'h14 |-> (prdata & 32'hffffd8ff) == 0)
      else $error("mask view shows unused bits");
   a_rx_upper: assert property (rd_acc && paddr == 8'h18 |-> prdata[31:8] == 24'h0)
      else $error("receive byte upper bits set");
   a_tx_start: assert property ($rose(line_oe) |-> !line_out)
      else $error("frame does not open with low start bit");
   a_tx_length: assert property ($rose(line_oe) |-> line_oe [*8])
      else $error("frame drive too short");
   a_mask_clear: assert property (wr_acc && paddr == 8'h10 && pwdata[15:8] == 8'h27 |=> !irq)
      else $error("irq stays after all masks cleared");
   a_flag_clear: assert property (wr_acc && paddr == 8'h08 && pwdata[15:8] == 8'h27 |=> !irq)
      else $error("irq stays after all flags cleared");
endmodule
bind single_pin_uart_user_if single_pin_uart_chk #(.ADDR_W(ADDR_W)) u_chk (.clk(clk), .nrst(nrst),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .osc_clock_on(osc_clock_on),
   .line_in(line_in), .line_out(line_out), .line_oe(line_oe), .irq(irq));
`default_nettype wire

// *** testbench/remote_serial_end.sv ***
// model of the remote asynchronous serial partner
`timescale 1ns/1ps
`default_nettype none
module remote_serial_end (
   input wire logic clk,
   input wire logic line_out,
   input wire logic line_oe,
   input wire logic [15:0] bit_cycles,
   output logic tx_line,
   output logic got_valid,
   output logic [7:0] got_byte
);
   initial begin
      tx_line = 1'b1;
      got_valid = 1'b0;
      got_byte = 8'h00;
   end
   // one frame: start low, data lsb first, stop high, then idle high
   task automatic send_byte(input logic [7:0] b, input int per);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         tx_line <= f[i];
         repeat (per) @(posedge clk);
      end
   endtask
   // mid bit sampling of frames sent by the block
   initial begin
      forever begin
         @(posedge clk);
         got_valid <= 1'b0;
         if (line_oe && !line_out) begin
            repeat (bit_cycles / 2) @(posedge clk);
            for (int i = 0; i < 8; i++) begin
               repeat (bit_cycles) @(posedge clk);
               got_byte[i] <= line_out;
            end
            repeat (bit_cycles) @(posedge clk);
            if (line_out) got_valid <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// *** testbench/testbench.sv ***
// self-checking testbench for the single pin uart register front end
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic osc_clock_on = 1'b1;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [15:0] bit_cycles = 16'h0008;
   logic [31:0] rd;
   logic [31:0] m;
   logic [31:0] c;
   logic [7:0] b0;
   logic [7:0] b1;
   wire logic [31:0] prdata;
   wire logic pready, pslverr, line_out, line_oe, irq, line_in, p_tx, got_valid;
   wire logic [7:0] got_byte;
   int err_total = 0;
   int check_count = 0;
   logic [31:0] exp_q[$];
   logic [31:0] msk_q[$];
   logic [7:0] byte_q[$];
   assign line_in = line_oe ? line_out : p_tx;
   single_pin_uart_user_if #(.ADDR_W(8), .DIV_W(16), .SYNC_CYCLES(4)) dut (.clk(clk),
      .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .osc_clock_on(osc_clock_on), .line_in(line_in), .line_out(line_out),
      .line_oe(line_oe), .irq(irq));
   remote_serial_end partner (.clk(clk), .line_out(line_out), .line_oe(line_oe),
      .bit_cycles(bit_cycles), .tx_line(p_tx), .got_valid(got_valid), .got_byte(got_byte));
   initial begin
      forever #25 clk = ~clk;
   end
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic summarize;
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // read: d is the expected word, mk the bits compared (zero for polling)
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [31:0] mk);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      if (!w) begin
         exp_q.push_back(d);
         msk_q.push_back(mk);
      end
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) err_total++;
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wait_idle;
      int n;
      n = 0;
      do begin
         apb(1'b0, 8'h04, 32'h0, 32'h0);
         n++;
      end while (rd[0] !== 1'b0 && n < 200);
      if (rd[0] !== 1'b0) err_total++;
   endtask
   // ----------------------------------------
   // result monitor
   // ----------------------------------------
   always @(posedge clk) begin
      if (psel && penable && !pwrite && pready === 1'b1 && exp_q.size() > 0) begin
         if (msk_q[0] != 0) check("read data", prdata & msk_q[0], exp_q[0] & msk_q[0]);
         void'(exp_q.pop_front());
         void'(msk_q.pop_front());
      end
      if (got_valid === 1'b1 && byte_q.size() > 0) check("sent byte", got_byte, byte_q.pop_front());
   end
   initial begin
      repeat (30000) @(posedge clk);
      err_total++;
      summarize();
   end
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial begin
      void'($urandom(32'hc81b));
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      for (int i = 0; i < 11; i++) apb(1'b0, 8'(i * 4), (i == 1) ? 32'h4 : 32'h0, 32'hffffffff);
      m = $urandom;
      osc_clock_on <= m[0];
      apb(1'b0, 8'h04, {29'h0, m[0], 2'b0}, 32'h4);
      m = $urandom & 32'h2700;
      c = $urandom & 32'h2700;
      apb(1'b1, 8'h0c, m, 32'h0);
      apb(1'b0, 8'h14, m, 32'hffffffff);
      apb(1'b1, 8'h10, c, 32'h0);
      apb(1'b0, 8'h14, m & ~c, 32'hffffffff);
      apb(1'b1, 8'h10, 32'h2700, 32'h0);
      apb(1'b1, 8'h00, 32'h2, 32'h0);
      apb(1'b0, 8'h04, 32'h1, 32'h1);
      wait_idle();
      apb(1'b0, 8'h04, 32'h100, 32'h100);
      apb(1'b1, 8'h20, 32'h40, 32'h0);
      apb(1'b1, 8'h20, 32'h99, 32'h0);
      wait_idle();
      apb(1'b0, 8'h20, 32'h40, 32'hffffffff);
      for (int k = 0; k < 2; k++) begin
         b0 = $urandom;
         byte_q.push_back(b0);
         apb(1'b1, 8'h1c, {24'h0, b0}, 32'h0);
         apb(1'b0, 8'h1c, {24'h0, b0}, 32'hffffffff);
         wait_idle();
      end
      repeat (20) @(posedge clk);
      check("frames left", byte_q.size(), 0);
      for (int md = 0; md < 4; md++) begin
         apb(1'b1, 8'h00, (md + 1) % 4, 32'h0);
         wait_idle();
         apb(1'b0, 8'h00, (md + 1) % 4, 32'hffffffff);
      end
      apb(1'b1, 8'h00, 32'h1, 32'h0);
      wait_idle();
      apb(1'b1, 8'h08, 32'h2700, 32'h0);
      apb(1'b1, 8'h0c, 32'h200, 32'h0);
      b0 = $urandom;
      b1 = $urandom;
      partner.send_byte(b0, 8);
      repeat (4) @(posedge clk);
      check("irq", {31'h0, irq}, 32'h1);
      apb(1'b0, 8'h04, 32'h200, 32'h600);
      apb(1'b0, 8'h18, {24'h0, b0}, 32'hffffffff);
      partner.send_byte(b1, 8);
      partner.send_byte(b0 ^ 8'h3c, 8);
      repeat (4) @(posedge clk);
      apb(1'b0, 8'h04, 32'h600, 32'h600);
      apb(1'b0, 8'h18, {24'h0, b0 ^ 8'h3c}, 32'hffffffff);
      apb(1'b1, 8'h08, 32'h400, 32'h0);
      apb(1'b0, 8'h04, 32'h200, 32'h600);
      check("irq", {31'h0, irq}, 32'h1);
      apb(1'b1, 8'h08, 32'h2700, 32'h0);
      check("irq", {31'h0, irq}, 32'h0);
      apb(1'b1, 8'h10, 32'h2700, 32'h0);
      apb(1'b1, 8'h00, 32'h3, 32'h0);
      wait_idle();
      partner.send_byte(8'h55, 12);
      repeat (20) @(posedge clk);
      apb(1'b0, 8'h20, 32'h60, 32'hffffffff);
      partner.send_byte(b1, 12);
      repeat (20) @(posedge clk);
      apb(1'b0, 8'h18, {24'h0, b1}, 32'hffffffff);
      summarize();
   end
endmodule
`default_nettype wire
